//--- hw/mgp_top.sv
`timescale 1ns/10ps
module mgp_top
    import mgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [22:0] gpio_pad_in,
    output logic [22:0] gpio_pad_out,
    output logic [22:0] gpio_pad_oe_n,
    output logic [7:0] output_only_pin,
    input wire logic [7:0] test_bus_in,
    input wire logic [15:0] rom_addr_pad_in,
    output logic [15:0] rom_addr_pad_out,
    output logic rom_addr_pad_oe_n,
    input wire logic [7:0] rom_data_in,
    input wire logic [15:0] fetch_addr,
    output logic [7:0] fetch_data,
    output logic internal_rom_sel,
    input wire logic [2:0] backlight_pulse_out,
    output logic counter_input,
    output logic ext_interrupt_in_n,
    input wire logic interrupt_out_n,
    input wire logic nv_store_clock,
    input wire logic nv_store_data_low,
    output logic nv_store_data,
    output logic host_serial_clock,
    output logic host_serial_data,
    input wire logic host_serial_data_low
);
    // ****************************************
    // registers
    // ****************************************
    logic [22:0] out_q, dir_q, od_q, alt_q;
    logic [7:0] gpo_q, tb_sel_q, tb_en_q;
    logic flash_we_n_q;
    logic [15:0] strap_q;
    logic strap_done_q;
    logic [22:0] sync1_q, sync2_q, prev_q;
    logic [22:0] pad_out_q, pad_oe_n_q;
    logic [7:0] gpo_pin_q;
    logic wr, rd;
    logic [9:0] idx;
    logic addr_ok;
    logic ext_rom, ddc_sel;
    logic [9:0] baud_div;
    // uart
    logic [9:0] tx_shift_q;
    logic [3:0] tx_bits_q;
    logic [9:0] tx_cnt_q;
    logic tx_line_q;
    mgp_rx_t rx_state_q;
    logic [9:0] rx_cnt_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_shift_q, rx_data_q;
    logic rx_valid_q, rx_done;
    // ddc
    logic display_channel_clock, display_channel_data, display_channel_clock_p, display_channel_data_p;
    logic [3:0] ddc_cnt_q;
    logic [7:0] ddc_shift_q, ddc_data_q;
    logic ddc_valid_q, ddc_done;
    // pad drive
    logic [22:0] drv_val, drv_en;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign idx = paddr[11:2];
    assign pready = 1'b1;
    assign ext_rom = strap_q[STRAP_EXT_ROM];
    assign ddc_sel = strap_q[STRAP_DDC_SEL];
    // ****************************************
    // strap capture
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_q <= 16'h0000;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q <= rom_addr_pad_in;
            strap_done_q <= 1'b1;
        end
    end
    // ****************************************
    // external rom port
    // ****************************************
    // pins stay inputs until the straps are caught
    assign rom_addr_pad_oe_n = !(strap_done_q && ext_rom);
    assign internal_rom_sel = !ext_rom;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_addr_pad_out <= 16'h0000;
            fetch_data <= 8'h00;
        end else begin
            rom_addr_pad_out <= fetch_addr;
            fetch_data <= rom_data_in;
        end
    end
    // ****************************************
    // apb registers
    // ****************************************
    always_comb begin
        addr_ok = 1'b1;
        prdata = 32'h00000000;
        case (idx)
            IDX_GPIO_OUT: prdata = {9'h000, out_q};
            IDX_GPIO_DIR: prdata = {9'h000, dir_q};
            IDX_GPIO_OD: prdata = {9'h000, od_q};
            IDX_GPIO_IN: prdata = {9'h000, sync2_q};
            IDX_ALT_EN: prdata = {9'h000, alt_q};
            IDX_STRAP: prdata = {16'h0000, strap_q};
            IDX_FLASH_WE: prdata = {31'h00000000, flash_we_n_q};
            IDX_UART_TX: prdata = {31'h00000000, tx_bits_q != 4'h0};
            IDX_UART_RX: prdata = {23'h000000, rx_valid_q, rx_data_q};
            IDX_DDC_RX: prdata = {23'h000000, ddc_valid_q, ddc_data_q};
            IDX_GPO: prdata = {24'h000000, gpo_q};
            IDX_TB_SEL: prdata = {24'h000000, tb_sel_q};
            IDX_TB_EN: prdata = {24'h000000, tb_en_q};
            default: addr_ok = 1'b0;
        endcase
        pslverr = psel && penable && !addr_ok;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 23'h000000;
            dir_q <= 23'h000000;
            od_q <= 23'h000000;
            alt_q <= RST_ALT_EN;
            gpo_q <= 8'h00;
            tb_sel_q <= RST_TB_SEL;
            tb_en_q <= RST_TB_EN;
            flash_we_n_q <= 1'b1;
        end else if (wr) begin
            case (idx)
                IDX_GPIO_OUT: out_q <= pwdata[22:0];
                IDX_GPIO_DIR: dir_q <= pwdata[22:0];
                IDX_GPIO_OD: od_q <= pwdata[22:0];
                IDX_ALT_EN: alt_q <= pwdata[22:0];
                IDX_FLASH_WE: flash_we_n_q <= pwdata[0];
                IDX_GPO: gpo_q <= pwdata[7:0];
                IDX_TB_SEL: tb_sel_q <= pwdata[7:0];
                IDX_TB_EN: tb_en_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // ****************************************
    // input synchroniser
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 23'h7fffff;
            sync2_q <= 23'h7fffff;
            prev_q <= 23'h7fffff;
        end else begin
            sync1_q <= gpio_pad_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign counter_input = sync2_q[3];
    assign ext_interrupt_in_n = alt_q[8] ? sync2_q[8] : 1'b1;
    assign nv_store_data = sync2_q[12];
    assign host_serial_clock = sync2_q[22];
    assign host_serial_data = sync2_q[16];
    // ****************************************
    // uart baud
    // ****************************************
    // code 00 is fast, all other codes slow
    assign baud_div = (strap_q[STRAP_BAUD_HI:STRAP_BAUD_LO] == 2'b00) ? DIV_FAST
                                                                       : DIV_SLOW;
    // ****************************************
    // uart transmit
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_q <= 10'h3ff;
            tx_bits_q <= 4'h0;
            tx_cnt_q <= 10'h000;
            tx_line_q <= 1'b1;
        end else if (tx_bits_q == 4'h0) begin
            tx_line_q <= 1'b1;
            // a write while busy is dropped, software polls busy first
            if (wr && idx == IDX_UART_TX) begin
                tx_shift_q <= {1'b1, pwdata[7:0], 1'b0};
                tx_bits_q <= 4'ha;
                tx_cnt_q <= 10'h000;
            end
        end else if (tx_cnt_q == 10'h000) begin
            tx_line_q <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_cnt_q <= baud_div - 10'h001;
            tx_bits_q <= tx_bits_q - 4'h1;
        end else begin
            tx_cnt_q <= tx_cnt_q - 10'h001;
        end
    end
    // ****************************************
    // uart receive
    // ****************************************
    assign rx_done = rx_state_q == MGP_RX_STOP && rx_cnt_q == 10'h000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= MGP_RX_IDLE;
            rx_cnt_q <= 10'h000;
            rx_bit_q <= 3'h0;
            rx_shift_q <= 8'h00;
        end else begin
            case (rx_state_q)
                MGP_RX_IDLE: begin
                    if (alt_q[4] && prev_q[4] && !sync2_q[4]) begin
                        rx_state_q <= MGP_RX_START;
                        rx_cnt_q <= {1'b0, baud_div[9:1]};
                    end
                end
                MGP_RX_START: begin
                    if (rx_cnt_q != 10'h000) begin
                        rx_cnt_q <= rx_cnt_q - 10'h001;
                    end else if (sync2_q[4]) begin
                        rx_state_q <= MGP_RX_IDLE; // glitch, not a start bit
                    end else begin
                        rx_state_q <= MGP_RX_DATA;
                        rx_cnt_q <= baud_div - 10'h001;
                        rx_bit_q <= 3'h0;
                    end
                end
                MGP_RX_DATA: begin
                    if (rx_cnt_q != 10'h000) begin
                        rx_cnt_q <= rx_cnt_q - 10'h001;
                    end else begin
                        rx_shift_q <= {sync2_q[4], rx_shift_q[7:1]};
                        rx_cnt_q <= baud_div - 10'h001;
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_state_q <= MGP_RX_STOP;
                        end
                    end
                end
                MGP_RX_STOP: begin
                    if (rx_cnt_q != 10'h000) begin
                        rx_cnt_q <= rx_cnt_q - 10'h001;
                    end else begin
                        rx_state_q <= MGP_RX_IDLE;
                    end
                end
                default: rx_state_q <= MGP_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else if (rx_done) begin
            rx_data_q <= rx_shift_q;
            rx_valid_q <= 1'b1; // new byte wins over the read clear
        end else if (rd && idx == IDX_UART_RX) begin
            rx_valid_q <= 1'b0;
        end
    end
    // ****************************************
    // ddc2bi receiver
    // ****************************************
    assign display_channel_clock = ddc_sel ? sync2_q[22] : sync2_q[15];
    assign display_channel_data = ddc_sel ? sync2_q[16] : sync2_q[14];
    assign display_channel_clock_p = ddc_sel ? prev_q[22] : prev_q[15];
    assign display_channel_data_p = ddc_sel ? prev_q[16] : prev_q[14];
    assign ddc_done = !display_channel_clock_p && display_channel_clock && ddc_cnt_q == 4'h7;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ddc_cnt_q <= 4'h0;
            ddc_shift_q <= 8'h00;
        end else if (display_channel_clock && display_channel_data_p && !display_channel_data) begin
            ddc_cnt_q <= 4'h0; // start condition realigns the byte
        end else if (!display_channel_clock_p && display_channel_clock) begin
            if (ddc_cnt_q == 4'h8) begin
                ddc_cnt_q <= 4'h0; // acknowledge slot is skipped
            end else begin
                ddc_shift_q <= {ddc_shift_q[6:0], display_channel_data};
                ddc_cnt_q <= ddc_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ddc_data_q <= 8'h00;
            ddc_valid_q <= 1'b0;
        end else if (ddc_done) begin
            ddc_data_q <= {ddc_shift_q[6:0], display_channel_data};
            ddc_valid_q <= 1'b1;
        end else if (rd && idx == IDX_DDC_RX) begin
            ddc_valid_q <= 1'b0;
        end
    end
    // ****************************************
    // pad drive and alternate functions
    // ****************************************
    always_comb begin
        for (int i = 0; i < GPIO_N; i++) begin
            // open drain only ever pulls low
            drv_val[i] = od_q[i] ? 1'b0 : out_q[i];
            drv_en[i] = dir_q[i] && !(od_q[i] && out_q[i]);
        end
        for (int i = 0; i < 3; i++) begin
            if (alt_q[i]) begin
                drv_val[i] = backlight_pulse_out[i];
                drv_en[i] = 1'b1;
            end
        end
        if (alt_q[3]) begin
            drv_en[3] = 1'b0;
        end
        if (alt_q[4]) begin
            drv_en[4] = 1'b0;
        end
        if (alt_q[5]) begin
            drv_val[5] = tx_line_q;
            drv_en[5] = 1'b1;
        end
        if (alt_q[8]) begin
            drv_en[8] = 1'b0;
        end
        if (alt_q[11]) begin
            drv_val[11] = flash_we_n_q;
            drv_en[11] = 1'b1;
        end
        if (alt_q[12]) begin
            drv_val[12] = 1'b0;
            drv_en[12] = nv_store_data_low;
        end
        if (alt_q[13]) begin
            drv_val[13] = nv_store_clock;
            drv_en[13] = 1'b1;
        end
        if (alt_q[16]) begin
            drv_val[16] = 1'b0;
            drv_en[16] = host_serial_data_low;
        end
        if (alt_q[21]) begin
            drv_val[21] = interrupt_out_n;
            drv_en[21] = 1'b1;
        end
        if (alt_q[22]) begin
            drv_en[22] = 1'b0;
        end
        // the pair carrying ddc is input only, it never turns into a gpio
        if (ddc_sel) begin
            drv_en[16] = 1'b0;
            drv_en[22] = 1'b0;
        end else begin
            drv_en[14] = 1'b0;
            drv_en[15] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out_q <= 23'h000000;
            pad_oe_n_q <= 23'h7fffff;
            gpo_pin_q <= 8'h00;
        end else begin
            pad_out_q <= drv_val;
            pad_oe_n_q <= ~drv_en;
            if (tb_sel_q == 8'h00 && tb_en_q[TB_EN_GPO_BIT]) begin
                gpo_pin_q <= gpo_q;
            end else begin
                gpo_pin_q <= test_bus_in;
            end
        end
    end

    assign gpio_pad_out = pad_out_q;
    assign gpio_pad_oe_n = pad_oe_n_q;
    assign output_only_pin = gpo_pin_q;
endmodule

//--- common/mgp_pkg.sv
package mgp_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int GPIO_N = 23;
    localparam int GPO_N = 8;
    localparam int STRAP_W = 16;
    // ****************************************
    // register indices, byte address is index * 4
    // ****************************************
    localparam logic [9:0] IDX_GPIO_OUT = 10'h000;
    localparam logic [9:0] IDX_GPIO_DIR = 10'h001;
    localparam logic [9:0] IDX_GPIO_OD = 10'h002;
    localparam logic [9:0] IDX_GPIO_IN = 10'h003;
    localparam logic [9:0] IDX_ALT_EN = 10'h004;
    localparam logic [9:0] IDX_STRAP = 10'h005;
    localparam logic [9:0] IDX_FLASH_WE = 10'h006;
    localparam logic [9:0] IDX_UART_TX = 10'h007;
    localparam logic [9:0] IDX_UART_RX = 10'h008;
    localparam logic [9:0] IDX_DDC_RX = 10'h009;
    localparam logic [9:0] IDX_GPO = 10'h00a;
    localparam logic [9:0] IDX_TB_SEL = 10'h1e6;
    localparam logic [9:0] IDX_TB_EN = 10'h1e7;
    // ****************************************
    // reset values and fields
    // ****************************************
    localparam logic [22:0] RST_ALT_EN = 23'h000000;
    localparam logic [7:0] RST_TB_SEL = 8'h00;
    localparam logic [7:0] RST_TB_EN = 8'h00;
    localparam int TB_EN_GPO_BIT = 2;
    localparam int STRAP_BAUD_LO = 10;
    localparam int STRAP_BAUD_HI = 11;
    localparam int STRAP_DDC_SEL = 12;
    localparam int STRAP_EXT_ROM = 14;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_FAST = 115_200;
    localparam int BAUD_SLOW = 57_600;
    localparam logic [9:0] DIV_FAST = 10'(CLK_HZ / BAUD_FAST);
    localparam logic [9:0] DIV_SLOW = 10'(CLK_HZ / BAUD_SLOW);
    typedef enum logic [1:0] {MGP_RX_IDLE, MGP_RX_START, MGP_RX_DATA, MGP_RX_STOP} mgp_rx_t;
endpackage

//--- verification/mgp_top_properties.sv
`timescale 1ns/10ps
module mgp_top_properties
    import mgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [22:0] gpio_pad_in,
    input wire logic [22:0] gpio_pad_out,
    input wire logic [22:0] gpio_pad_oe_n,
    input wire logic [7:0] output_only_pin,
    input wire logic [7:0] test_bus_in,
    input wire logic [15:0] rom_addr_pad_in,
    input wire logic [15:0] rom_addr_pad_out,
    input wire logic rom_addr_pad_oe_n,
    input wire logic [15:0] fetch_addr,
    input wire logic internal_rom_sel,
    input wire logic [2:0] backlight_pulse_out,
    input wire logic ext_interrupt_in_n
);
    // ****************************************
    // register mirrors
    // ****************************************
    // pins with no alternate role and no strap-dependent role
    localparam logic [22:0] PLAIN = 23'h1e06c0;
    logic [22:0] out_q, dir_q, od_q, alt_q;
    logic [7:0] gpo_q, sel_q, en_q, gpo_exp;
    logic [15:0] strap_q;
    logic fl_q, cap_q, wr;
    assign wr = psel && penable && pwrite && pready && !pslverr;
    assign gpo_exp = (sel_q == 8'h00 && en_q[TB_EN_GPO_BIT]) ? gpo_q : test_bus_in;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {out_q, dir_q, od_q} <= '0;
            alt_q <= RST_ALT_EN;
            {gpo_q, sel_q, en_q} <= '0;
            fl_q <= 1'b1;
        end else if (wr) begin
            case (paddr[11:2])
                IDX_GPIO_OUT: out_q <= pwdata[22:0];
                IDX_GPIO_DIR: dir_q <= pwdata[22:0];
                IDX_GPIO_OD: od_q <= pwdata[22:0];
                IDX_ALT_EN: alt_q <= pwdata[22:0];
                IDX_FLASH_WE: fl_q <= pwdata[0];
                IDX_GPO: gpo_q <= pwdata[7:0];
                IDX_TB_SEL: sel_q <= pwdata[7:0];
                IDX_TB_EN: en_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // one capture only, so a pad that later drives cannot alter it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {cap_q, strap_q} <= '0;
        end else if (!cap_q) begin
            cap_q <= 1'b1;
            strap_q <= rom_addr_pad_in;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_rd_pin;
        psel && penable && !pwrite && paddr[11:2] == IDX_GPIO_IN;
    endsequence
    sequence s_rd_strap;
        psel && penable && !pwrite && paddr[11:2] == IDX_STRAP;
    endsequence
    a_rom_sel_strap:
        assert property (internal_rom_sel == !strap_q[STRAP_EXT_ROM])
        else $error("rom select does not follow strap");
    a_rom_pads_drive:
        assert property (rom_addr_pad_oe_n == internal_rom_sel)
        else $error("rom address pads driven in wrong mode");
    a_rom_addr_out:
        assert property (!rom_addr_pad_oe_n |=> rom_addr_pad_out == $past(fetch_addr))
        else $error("rom address not presented next cycle");
    a_strap_read:
        assert property (s_rd_strap |-> prdata == {16'h0000, strap_q})
        else $error("strap read differs from captured value");
    a_pin_read:
        assert property (s_rd_pin |-> prdata[22:0] == $past(gpio_pad_in, 2))
        else $error("pin read not two stages behind pad");
    a_gpo_select:
        assert property (rst_n |=> output_only_pin == $past(gpo_exp))
        else $error("output only pins wrong source");
    a_gpio_drive:
        assert property (1'b1 |=> ((gpio_pad_oe_n ^ $past(~(dir_q & (~od_q | ~out_q))))
            & $past(~alt_q) & PLAIN) == 23'h0)
        else $error("pin enable disagrees with direction and open drain");
    a_flash_strobe:
        assert property (alt_q[11] |=> gpio_pad_out[11] == $past(fl_q) && !gpio_pad_oe_n[11])
        else $error("flash strobe not on its pin");
    a_backlight_alt:
        assert property (1'b1 |=> ((gpio_pad_out[2:0] ^ $past(backlight_pulse_out))
            & $past(alt_q[2:0])) == 3'h0)
        else $error("backlight pulse not on its pin");
    a_irq_in_gate:
        assert property ($stable(alt_q[8]) |-> ext_interrupt_in_n ==
            (alt_q[8] ? $past(gpio_pad_in[8], 2) : 1'b1))
        else $error("interrupt input gating wrong");
endmodule
bind mgp_top mgp_top_properties u_props (.*);

//--- verification/mgp_pad_model.sv
`timescale 1ns/10ps
module mgp_pad_model (
    input wire logic [22:0] gpio_pad_out,
    input wire logic [22:0] gpio_pad_oe_n,
    input wire logic [22:0] ext_lvl,
    input wire logic [15:0] strap,
    input wire logic [15:0] rom_addr_pad_out,
    input wire logic rom_addr_pad_oe_n,
    output logic [22:0] gpio_pad_in,
    output logic [15:0] rom_addr_pad_in,
    output logic [7:0] rom_data_in
);
    logic [22:0] lvl;
    // pulled-up wires: a released pin shows only what the far side pulls
    assign lvl = ext_lvl & (gpio_pad_oe_n | gpio_pad_out);
    // uart receive looped from transmit
    assign gpio_pad_in = {lvl[22:5], lvl[4] & lvl[5], lvl[3:0]};
    assign rom_addr_pad_in = rom_addr_pad_oe_n ? strap : rom_addr_pad_out;
    // rom keeps pace: data settles within the cycle of its address
    assign rom_data_in = rom_addr_pad_out[7:0] ^ rom_addr_pad_out[15:8];
endmodule

//--- verification/mgp_top_tb_top.sv
`timescale 1ns/10ps
module mgp_top_tb_top;
    import mgp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, last_rd;
    logic pready, pslverr, last_err;
    logic [22:0] gpio_pad_in, gpio_pad_out, gpio_pad_oe_n;
    logic [22:0] ext_lvl = 23'h7fffff;
    logic [15:0] strap = 16'h0;
    logic [7:0] output_only_pin, rom_data_in, fetch_data;
    logic [7:0] test_bus_in = 8'h3c;
    logic [15:0] rom_addr_pad_in, rom_addr_pad_out;
    logic [15:0] fetch_addr = 16'h0;
    logic rom_addr_pad_oe_n, internal_rom_sel, counter_input, ext_interrupt_in_n;
    logic nv_store_data, host_serial_clock, host_serial_data;
    logic [2:0] backlight_pulse_out = 3'h5;
    logic interrupt_out_n = 1'b1;
    logic nv_store_clock = 1'b1;
    logic nv_store_data_low = 1'b0;
    logic host_serial_data_low = 1'b0;
    logic [7:0] tsel [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] ten [4] = '{8'h00, 8'h04, 8'h04, 8'hfb};
    logic [7:0] texp [4] = '{8'h3c, 8'h81, 8'h3c, 8'h3c};
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    mgp_top DUT (.*);
    mgp_pad_model u_pads (.*);
    // ****************************************
    // bus and checking tasks
    // ****************************************
    task automatic final_report();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready) begin
            last_rd <= prdata;
            last_err <= pslverr;
        end
        if (cyc == 40000) begin
            fails++;
            final_report();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one idle edge after each transfer lets read data settle in last_rd
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        rd = last_rd;
    endtask
    task automatic do_reset(input logic [15:0] s);
        rst_n <= 1'b0;
        strap <= s;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic uart_run(input int div);
        int n;
        n = 0;
        apb(1'b1, IDX_ALT_EN, 32'h30);
        apb(1'b1, IDX_UART_TX, 32'ha7);
        apb(1'b0, IDX_UART_TX, 32'h0);
        cmp(rd, 32'h1);
        // bits 3 and 4 of 0xa7 form the first low run after the start bit
        while (gpio_pad_out[5] !== 1'b1) @(posedge clk);
        while (gpio_pad_out[5] !== 1'b0) @(posedge clk);
        while (gpio_pad_out[5] !== 1'b1) begin
            n++;
            @(posedge clk);
        end
        cmp(n, 2 * div);
        do apb(1'b0, IDX_UART_RX, 32'h0); while (rd[8] !== 1'b1);
        cmp(rd, 32'h1a7);
        apb(1'b0, IDX_UART_RX, 32'h0);
        cmp(rd & 32'h100, 32'h0);
    endtask
    task automatic ddc_send(input int c, input int d, input logic [7:0] b);
        ext_lvl[d] <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 8; i >= 0; i--) begin
            ext_lvl[c] <= 1'b0;
            repeat (8) @(posedge clk);
            ext_lvl[d] <= (i > 0) ? b[i - 1] : 1'b1;
            repeat (8) @(posedge clk);
            ext_lvl[c] <= 1'b1;
            repeat (8) @(posedge clk);
        end
        ext_lvl[d] <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b0, IDX_DDC_RX, 32'h0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        do_reset(16'h00a5);
        apb(1'b0, IDX_STRAP, 32'h0);
        cmp(rd, 32'h00a5);
        cmp({internal_rom_sel, rom_addr_pad_oe_n}, 2'b11);
        apb(1'b0, IDX_TB_EN, 32'h0);
        cmp(rd, {24'h0, RST_TB_EN});
        apb(1'b0, 10'h0ff, 32'h0);
        cmp({last_err, rd[30:0]}, 32'h80000000);
        apb(1'b1, IDX_GPO, 32'h81);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, IDX_TB_SEL, {24'h0, tsel[k]});
            apb(1'b1, IDX_TB_EN, {24'h0, ten[k]});
            @(posedge clk);
            cmp(output_only_pin, texp[k]);
        end
        apb(1'b1, IDX_GPIO_OUT, 32'h0a0280);
        apb(1'b1, IDX_GPIO_DIR, 32'h1e06c0);
        @(posedge clk);
        cmp(gpio_pad_oe_n & 23'h1e06c0, 23'h0);
        cmp(gpio_pad_out & 23'h1e06c0, 23'h0a0280);
        apb(1'b1, IDX_GPIO_OD, 32'h1e06c0);
        ext_lvl <= 23'h77ffff;
        @(posedge clk);
        cmp(gpio_pad_oe_n & 23'h1e06c0, 23'h0a0280);
        apb(1'b0, IDX_GPIO_IN, 32'h0);
        cmp(rd & 32'h1e06c0, 32'h020280);
        {interrupt_out_n, nv_store_clock, nv_store_data_low} <= 3'b001;
        apb(1'b1, IDX_FLASH_WE, 32'h0);
        apb(1'b1, IDX_ALT_EN, 32'h7fffff);
        ext_lvl <= 23'h3ffef7;
        repeat (3) @(posedge clk);
        cmp(gpio_pad_out & 23'h203807, 23'h000005);
        cmp(gpio_pad_oe_n & 23'h203807, 23'h0);
        cmp({ext_interrupt_in_n, counter_input, host_serial_clock, nv_store_data, host_serial_data},
            5'h01);
        ext_lvl <= 23'h7fffff;
        uart_run(DIV_FAST);
        ddc_send(15, 14, 8'h6b);
        cmp(rd, 32'h16b);
        ddc_send(22, 16, 8'h5e);
        cmp(rd & 32'h100, 32'h0);
        do_reset(16'h5400);
        cmp({internal_rom_sel, rom_addr_pad_oe_n}, 2'b00);
        fetch_addr <= 16'h1234;
        repeat (3) @(posedge clk);
        cmp({rom_addr_pad_out, fetch_data}, 24'h123426);
        uart_run(DIV_SLOW);
        ddc_send(22, 16, 8'h5e);
        cmp(rd, 32'h15e);
        final_report();
    end
endmodule
